/* core/ppfm_pin_sync.sv */
`timescale 1ns/10ps
module ppfm_pin_sync
  import ppfm_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              reset,
  input  wire logic              clk_en,
  input  wire logic [SYNC_W-1:0] raw,
  output logic      [SYNC_W-1:0] stable
);

  logic [SYNC_W-1:0] s1;
  logic [SYNC_W-1:0] s2;
  logic [SYNC_W-1:0] s3;
  logic [SYNC_W-1:0] next_stable;

  // ---------------------------------------------------------------------------
  // Accept a change once stages two and three agree
  // ---------------------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < SYNC_W; i++) begin
      next_stable[i] = (s2[i] == s3[i]) ? s3[i] : stable[i];
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      s1     <= SYNC_RST;
      s2     <= SYNC_RST;
      s3     <= SYNC_RST;
      stable <= SYNC_RST;
    end else if (clk_en) begin
      s1     <= raw;
      s2     <= s1;
      s3     <= s2;
      stable <= next_stable;
    end
  end

endmodule // ppfm_pin_sync

/* core/ppfm_pkg.sv */
package ppfm_pkg;

  // ---------------------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------------------
  localparam int P0_W    = 8;
  localparam int P1_W    = 8;
  localparam int P2_W    = 8;
  localparam int P3_W    = 6;
  localparam int P4_W    = 4;
  localparam int P7_W    = 4;
  localparam int SEGP_W  = 28;
  localparam int SEGS_W  = 12;
  localparam int IRQ_N   = 7;
  localparam int IO_W    = P0_W + P2_W + P3_W + P4_W + P7_W + SEGP_W;
  localparam int SYNC_W  = IO_W + P1_W;

  // ---------------------------------------------------------------------------
  // Reset values (direction bit 1 = input)
  // ---------------------------------------------------------------------------
  localparam logic [IO_W-1:0]   DIR_RST    = {IO_W{1'b1}};
  localparam logic [IO_W-1:0]   IO_RST     = {IO_W{1'b0}};
  localparam logic [SYNC_W-1:0] SYNC_RST   = {SYNC_W{1'b0}};
  localparam logic [SEGS_W-1:0] SEG_RST    = 12'h000;
  localparam logic [P1_W-1:0]   P1_RST     = 8'h00;
  localparam logic [IRQ_N-1:0]  IRQ_RST    = 7'h00;

  // ---------------------------------------------------------------------------
  // Pin positions of alternate functions
  // ---------------------------------------------------------------------------
  localparam int P0_ADC_TRIG  = 3;
  localparam int P0_TRIM_CLK  = 5;
  localparam int P0_TMR_B_OUT = 6;
  localparam int P0_TMR_A_OUT = 7;
  localparam int P2_CSI2_DIN  = 0;
  localparam int P2_CSI2_DOUT = 1;
  localparam int P2_CSI2_CLK  = 2;
  localparam int P2_CSI1_DIN  = 3;
  localparam int P2_CSI1_DOUT = 4;
  localparam int P2_CSI1_CLK  = 5;
  localparam int P2_RXD  = 6;
  localparam int P2_TXD  = 7;
  localparam int P3_TW_CLK = 0;
  localparam int P3_TW_DAT = 1;
  localparam int P3_T8B    = 2;
  localparam int P3_T8A    = 3;
  localparam int P3_T16B   = 4;
  localparam int P3_T16A   = 5;

  typedef enum logic [1:0] {
    EDGE_NONE,
    EDGE_RISE,
    EDGE_FALL,
    EDGE_BOTH
  } ppfm_edge_t;

  typedef struct packed {
    logic [P0_W-1:0]   p0;
    logic [P2_W-1:0]   p2;
    logic [P3_W-1:0]   p3;
    logic [P4_W-1:0]   p4;
    logic [P7_W-1:0]   p7;
    logic [SEGP_W-1:0] seg;
  } ppfm_io_t;

  typedef struct packed {
    logic trim_clock_out;
    logic timer_a_out;
    logic timer_b_out;
    logic csi_first_data_out;
    logic csi_second_data_out;
    logic csi_first_clock_out;
    logic csi_first_clock_oe;
    logic csi_second_clock_out;
    logic csi_second_clock_oe;
    logic async_transmit_line;
    logic two_wire_clock_out;
    logic two_wire_data_out;
    logic timer16_out;
    logic timer8_first_out;
    logic timer8_second_out;
  } ppfm_periph_out_t;

  typedef struct packed {
    logic adc_ext_trigger;
    logic timer_b_count_in;
    logic csi_first_data_in;
    logic csi_second_data_in;
    logic csi_first_clock;
    logic csi_second_clock;
    logic async_receive_line;
    logic two_wire_clock_line;
    logic two_wire_data_line;
    logic timer16_count_capture_in;
    logic timer16_capture_in;
    logic timer16_capture_reg_a_trig;
    logic timer16_capture_reg_b_trig;
    logic timer8_first_count_in;
    logic timer8_second_count_in;
  } ppfm_periph_in_t;

endpackage

/* core/ppfm_port_mux.sv */
`timescale 1ns/10ps
module ppfm_port_mux
  import ppfm_pkg::*;
#(
  parameter logic            HAS_TWO_WIRE      = 1'b0,
  parameter logic [1:0]      PORT3_FIXED_PULLUP = 2'h0,
  parameter logic [P7_W-1:0] PORT7_FIXED_PULLUP = 4'h0
) (
  input  wire logic              mclk,
  input  wire logic              reset,
  input  wire logic              clk_en,
  input  wire logic [P0_W-1:0]   port0_direction_reg,
  input  wire logic [P0_W-1:0]   port0_pullup_reg,
  input  wire logic [P0_W-1:0]   port0_mode,
  input  wire logic [P1_W-1:0]   port1_mode,
  input  wire logic [P2_W-1:0]   port2_direction_reg,
  input  wire logic [P2_W-1:0]   port2_pullup_reg,
  input  wire logic [P2_W-1:0]   port2_mode,
  input  wire logic [P3_W-1:0]   port3_direction_reg,
  input  wire logic [P3_W-1:2]   port3_pullup_reg,
  input  wire logic [P3_W-1:0]   port3_mode,
  input  wire logic [P4_W-1:0]   port4_direction_reg,
  input  wire logic [P4_W-1:0]   port4_pullup_reg,
  input  wire logic [P7_W-1:0]   port7_direction_reg,
  input  wire logic [SEGP_W-1:0] seg_port_direction_reg,
  input  wire logic [SEGP_W-1:0] pin_function_reg,
  input  wire ppfm_io_t          port_latch,
  input  wire ppfm_io_t          pin_in,
  input  wire logic [P1_W-1:0]   port1_pin_in,
  output ppfm_io_t               pin_out,
  output ppfm_io_t               pin_oe,
  output ppfm_io_t               pullup_en,
  output ppfm_io_t               port_read,
  output logic      [P1_W-1:0]   port1_read,
  output logic      [P1_W-1:0]   adc_analog_inputs,
  input  wire ppfm_edge_t [IRQ_N-1:0] ext_irq_edge,
  output logic      [IRQ_N-1:0]  ext_irq_inputs,
  input  wire logic              key_flag_clear,
  output logic                   key_edge_request_flag,
  input  wire ppfm_periph_out_t  periph_out,
  output ppfm_periph_in_t        periph_in,
  input  wire logic [SEGS_W-1:0] seg_static_sel,
  input  wire logic [SEGS_W-1:0] seg_static_data,
  input  wire logic [SEGS_W-1:0] seg_dynamic_data,
  input  wire logic [SEGP_W-1:0] dynamic_segment_outputs,
  output logic      [SEGS_W-1:0] static_capable_segments
);

  function automatic logic edge_hit(input ppfm_edge_t mode, input logic prev,
                                    input logic cur);
    case (mode)
      EDGE_RISE: edge_hit = ~prev & cur;
      EDGE_FALL: edge_hit = prev & ~cur;
      EDGE_BOTH: edge_hit = prev ^ cur;
      default:   edge_hit = 1'b0;
    endcase
  endfunction

  // ---------------------------------------------------------------------------
  // Pin sampling
  // ---------------------------------------------------------------------------
  logic [SYNC_W-1:0] sync_all;
  ppfm_io_t          smp;
  logic [P1_W-1:0]   smp_p1;
  ppfm_io_t          dir;

  ppfm_pin_sync u_sync (
    .mclk   (mclk),
    .reset  (reset),
    .clk_en (clk_en),
    .raw    ({port1_pin_in, pin_in}),
    .stable (sync_all)
  );

  assign smp    = sync_all[IO_W-1:0];
  assign smp_p1 = sync_all[SYNC_W-1:IO_W];
  assign dir    = {port0_direction_reg, port2_direction_reg, port3_direction_reg,
                   port4_direction_reg, port7_direction_reg, seg_port_direction_reg};

  // ---------------------------------------------------------------------------
  // Edge history
  // ---------------------------------------------------------------------------
  logic [IRQ_N-1:0] prev_irq;
  logic [P4_W-1:0]  prev_key;
  logic [1:0]       prev_t16;
  logic [IRQ_N-1:0] irq_hit;
  logic [IRQ_N-1:0] next_ext_irq;
  logic             next_key_flag;

  genvar gi;
  generate
    for (gi = 0; gi < IRQ_N; gi++) begin : g_irq
      assign irq_hit[gi] = port0_mode[gi] &
                           edge_hit(ext_irq_edge[gi], prev_irq[gi], smp.p0[gi]);
    end
  endgenerate

  always_comb begin
    next_ext_irq  = irq_hit;
    // Set wins over a clear in the same cycle
    next_key_flag = (key_edge_request_flag & ~key_flag_clear) |
                    (|(prev_key & ~smp.p4));
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      prev_irq              <= IRQ_RST;
      prev_key              <= {P4_W{1'b0}};
      prev_t16              <= 2'h0;
      ext_irq_inputs        <= IRQ_RST;
      key_edge_request_flag <= 1'b0;
    end else if (clk_en) begin
      prev_irq              <= smp.p0[IRQ_N-1:0];
      prev_key              <= smp.p4;
      prev_t16              <= {smp.p3[P3_T16A], smp.p3[P3_T16B]};
      ext_irq_inputs        <= next_ext_irq;
      key_edge_request_flag <= next_key_flag;
    end
  end

  // ---------------------------------------------------------------------------
  // Pin drive, pull-ups and read-back
  // ---------------------------------------------------------------------------
  ppfm_io_t          next_out;
  ppfm_io_t          next_oe;
  ppfm_io_t          next_pu;
  ppfm_io_t          next_read;
  logic [P1_W-1:0]   next_p1_read;
  logic [P1_W-1:0]   next_ani;
  ppfm_periph_in_t   next_pin_in;
  logic [SEGS_W-1:0] next_seg;

  always_comb begin
    // Output direction drives the latch, input reads the pin
    next_oe   = ~dir;
    next_out  = port_latch;
    next_read = ppfm_io_t'((dir & smp) | (~dir & port_latch));

    // Open-drain pins only pull low
    next_out.p3[1:0] = 2'h0;
    next_oe.p3[1:0]  = ~port3_direction_reg[1:0] & ~port_latch.p3[1:0];
    next_out.p7      = {P7_W{1'b0}};
    next_oe.p7       = ~port7_direction_reg & ~port_latch.p7;

    // Port 0 alternate functions
    for (int i = 0; i < P0_TRIM_CLK; i++) begin
      if (port0_mode[i]) begin
        next_oe.p0[i] = 1'b0;
      end
    end
    if (port0_mode[P0_TRIM_CLK]) begin
      next_out.p0[P0_TRIM_CLK] = periph_out.trim_clock_out;
      next_oe.p0[P0_TRIM_CLK]  = ~port0_direction_reg[P0_TRIM_CLK];
    end
    if (port0_mode[P0_TMR_B_OUT]) begin
      next_out.p0[P0_TMR_B_OUT] = periph_out.timer_b_out;
    end
    if (port0_mode[P0_TMR_A_OUT]) begin
      next_out.p0[P0_TMR_A_OUT] = periph_out.timer_a_out;
    end

    // Port 2 serial lines
    if (port2_mode[P2_CSI2_DIN]) begin
      next_oe.p2[P2_CSI2_DIN] = 1'b0;
    end
    if (port2_mode[P2_CSI2_DOUT]) begin
      next_out.p2[P2_CSI2_DOUT] = periph_out.csi_second_data_out;
      next_oe.p2[P2_CSI2_DOUT]  = 1'b1;
    end
    if (port2_mode[P2_CSI2_CLK]) begin
      next_out.p2[P2_CSI2_CLK] = periph_out.csi_second_clock_out;
      next_oe.p2[P2_CSI2_CLK]  = periph_out.csi_second_clock_oe;
    end
    if (port2_mode[P2_CSI1_DIN]) begin
      next_oe.p2[P2_CSI1_DIN] = 1'b0;
    end
    if (port2_mode[P2_CSI1_DOUT]) begin
      next_out.p2[P2_CSI1_DOUT] = periph_out.csi_first_data_out;
      next_oe.p2[P2_CSI1_DOUT]  = 1'b1;
    end
    if (port2_mode[P2_CSI1_CLK]) begin
      next_out.p2[P2_CSI1_CLK] = periph_out.csi_first_clock_out;
      next_oe.p2[P2_CSI1_CLK]  = periph_out.csi_first_clock_oe;
    end
    if (port2_mode[P2_RXD]) begin
      next_oe.p2[P2_RXD] = 1'b0;
    end
    if (port2_mode[P2_TXD]) begin
      next_out.p2[P2_TXD] = periph_out.async_transmit_line;
      next_oe.p2[P2_TXD]  = 1'b1;
    end

    // Port 3 two-wire and timer lines
    if (HAS_TWO_WIRE && port3_mode[P3_TW_CLK]) begin
      next_oe.p3[P3_TW_CLK] = ~periph_out.two_wire_clock_out;
    end
    if (HAS_TWO_WIRE && port3_mode[P3_TW_DAT]) begin
      next_oe.p3[P3_TW_DAT] = ~periph_out.two_wire_data_out;
    end
    if (port3_mode[P3_T8B]) begin
      next_out.p3[P3_T8B] = periph_out.timer8_second_out;
    end
    if (port3_mode[P3_T8A]) begin
      next_out.p3[P3_T8A] = periph_out.timer8_first_out;
    end
    if (port3_mode[P3_T16B]) begin
      next_out.p3[P3_T16B] = periph_out.timer16_out;
    end
    if (port3_mode[P3_T16A]) begin
      next_oe.p3[P3_T16A] = 1'b0;
    end

    // Ports 8 to 11 as segment outputs
    for (int i = 0; i < SEGP_W; i++) begin
      if (pin_function_reg[i]) begin
        next_out.seg[i] = dynamic_segment_outputs[i];
        next_oe.seg[i]  = 1'b1;
      end
    end

    // Pull-ups
    next_pu         = IO_RST;
    next_pu.p0      = port0_pullup_reg;
    next_pu.p2      = port2_pullup_reg;
    next_pu.p3[1:0] = PORT3_FIXED_PULLUP;
    next_pu.p3[5:2] = port3_pullup_reg;
    next_pu.p4      = port4_pullup_reg;
    next_pu.p7      = PORT7_FIXED_PULLUP;

    // Port 1: digital read in port mode, analog channel in control mode
    next_p1_read = smp_p1 & ~port1_mode;
    next_ani     = smp_p1 & port1_mode;

    // Signals towards the peripherals
    next_pin_in.adc_ext_trigger     = port0_mode[P0_ADC_TRIG] & smp.p0[P0_ADC_TRIG];
    next_pin_in.timer_b_count_in    = port0_mode[P0_TMR_A_OUT] &
                                      port0_direction_reg[P0_TMR_A_OUT] &
                                      smp.p0[P0_TMR_A_OUT];
    next_pin_in.csi_second_data_in  = port2_mode[P2_CSI2_DIN] & smp.p2[P2_CSI2_DIN];
    next_pin_in.csi_second_clock    = port2_mode[P2_CSI2_CLK] & smp.p2[P2_CSI2_CLK];
    next_pin_in.csi_first_data_in   = port2_mode[P2_CSI1_DIN] & smp.p2[P2_CSI1_DIN];
    next_pin_in.csi_first_clock     = port2_mode[P2_CSI1_CLK] & smp.p2[P2_CSI1_CLK];
    next_pin_in.async_receive_line  = port2_mode[P2_RXD] & smp.p2[P2_RXD];
    next_pin_in.two_wire_clock_line = HAS_TWO_WIRE & port3_mode[P3_TW_CLK] &
                                      smp.p3[P3_TW_CLK];
    next_pin_in.two_wire_data_line  = HAS_TWO_WIRE & port3_mode[P3_TW_DAT] &
                                      smp.p3[P3_TW_DAT];
    next_pin_in.timer8_second_count_in = port3_mode[P3_T8B] & smp.p3[P3_T8B];
    next_pin_in.timer8_first_count_in  = port3_mode[P3_T8A] & smp.p3[P3_T8A];
    next_pin_in.timer16_capture_in  = port3_mode[P3_T16B] & smp.p3[P3_T16B];
    next_pin_in.timer16_count_capture_in = port3_mode[P3_T16A] & smp.p3[P3_T16A];
    // Rising edge of the first input captures both, of the second the first only
    next_pin_in.timer16_capture_reg_b_trig = port3_mode[P3_T16A] &
                                             ~prev_t16[1] & smp.p3[P3_T16A];
    next_pin_in.timer16_capture_reg_a_trig = next_pin_in.timer16_capture_reg_b_trig |
                                             (port3_mode[P3_T16B] &
                                              port3_direction_reg[P3_T16B] &
                                              ~prev_t16[0] & smp.p3[P3_T16B]);

    // Dedicated segments
    for (int i = 0; i < SEGS_W; i++) begin
      next_seg[i] = seg_static_sel[i] ? seg_static_data[i] : seg_dynamic_data[i];
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      pin_out                 <= IO_RST;
      pin_oe                  <= IO_RST;
      pullup_en               <= IO_RST;
      port_read               <= IO_RST;
      port1_read              <= P1_RST;
      adc_analog_inputs       <= P1_RST;
      periph_in               <= '0;
      static_capable_segments <= SEG_RST;
    end else if (clk_en) begin
      pin_out                 <= next_out;
      pin_oe                  <= next_oe;
      pullup_en               <= next_pu;
      port_read               <= next_read;
      port1_read              <= next_p1_read;
      adc_analog_inputs       <= next_ani;
      periph_in               <= next_pin_in;
      static_capable_segments <= next_seg;
    end
  end

endmodule // ppfm_port_mux

/* verif/ppfm_board_model.sv */
`timescale 1ns/10ps
module ppfm_board_model
  import ppfm_pkg::*;
(
  input  wire logic     mclk,
  input  wire ppfm_io_t pin_out,
  input  wire ppfm_io_t pin_oe,
  input  wire ppfm_io_t pullup_en,
  input  wire ppfm_io_t ext_level,
  input  wire ppfm_io_t ext_drive,
  output ppfm_io_t      pin_in
);
  // ---------------------------------------------------------------------------
  // Pin resolution
  // ---------------------------------------------------------------------------
  logic [IO_W-1:0] drift = {29{2'b01}};

  // An open pin wanders every cycle so no stale level can pass for a read
  always @(posedge mclk) begin
    drift <= ~drift;
  end

  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_drive & ext_level)
                | (~pin_oe & ~ext_drive & pullup_en)
                | (~pin_oe & ~ext_drive & ~pullup_en & drift);
endmodule // ppfm_board_model

/* verif/ppfm_port_mux_props.sv */
`timescale 1ns/10ps
module ppfm_port_mux_props
  import ppfm_pkg::*;
(
  input wire logic              mclk,
  input wire logic              reset,
  input wire logic              clk_en,
  input wire logic [P0_W-1:0]   port0_direction_reg,
  input wire logic [P0_W-1:0]   port0_mode,
  input wire logic [P1_W-1:0]   port1_mode,
  input wire logic [P7_W-1:0]   port7_direction_reg,
  input wire logic [SEGP_W-1:0] pin_function_reg,
  input wire ppfm_io_t          port_latch,
  input wire ppfm_io_t          pin_out,
  input wire ppfm_io_t          pin_oe,
  input wire ppfm_io_t          port_read,
  input wire logic [P1_W-1:0]   port1_read,
  input wire logic [P1_W-1:0]   adc_analog_inputs,
  input wire logic [IRQ_N-1:0]  ext_irq_inputs,
  input wire logic              key_flag_clear,
  input wire logic              key_edge_request_flag,
  input wire ppfm_periph_in_t   periph_in,
  input wire logic [SEGS_W-1:0] seg_static_sel,
  input wire logic [SEGS_W-1:0] seg_static_data,
  input wire logic [SEGS_W-1:0] seg_dynamic_data,
  input wire logic [SEGP_W-1:0] dynamic_segment_outputs,
  input wire logic [SEGS_W-1:0] static_capable_segments
);
  // ---------------------------------------------------------------------------
  // Port behaviour
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  sequence pulse_s;
    |ext_irq_inputs;
  endsequence

  sequence flag_kept_s;
    key_edge_request_flag && !key_flag_clear;
  endsequence

  dir_p0_a: assert property (clk_en |=> ((pin_oe.p0 ^ ~$past(port0_direction_reg))
    & ~$past(port0_mode)) == 8'h00) else $error("port 0 enable does not follow direction");
  read_p0_a: assert property (clk_en |=> ((port_read.p0 ^ $past(port_latch.p0))
    & ~$past(port0_direction_reg)) == 8'h00) else $error("port 0 output bit read wrong");
  od_p7_a: assert property (clk_en |=> pin_out.p7 == 4'h0 && pin_oe.p7 ==
    (~$past(port7_direction_reg) & ~$past(port_latch.p7))) else $error("port 7 not open drain");
  od_p3_a: assert property (pin_out.p3[1:0] == 2'h0)
    else $error("port 3 low pins drive high");
  p1_split_a: assert property (clk_en |=> (adc_analog_inputs & ~$past(port1_mode)) == 8'h00
    && (port1_read & $past(port1_mode)) == 8'h00) else $error("port 1 routing wrong");
  irq_pulse_a: assert property (pulse_s |=> (ext_irq_inputs & $past(ext_irq_inputs)) == 7'h00)
    else $error("interrupt pulse longer than one cycle");
  key_hold_a: assert property (flag_kept_s |=> key_edge_request_flag)
    else $error("key flag dropped without clear");
  cap_pair_a: assert property (periph_in.timer16_capture_reg_b_trig
    |-> periph_in.timer16_capture_reg_a_trig) else $error("capture b without capture a");
  seg_sel_a: assert property (clk_en |=> static_capable_segments ==
    (($past(seg_static_sel) & $past(seg_static_data)) | (~$past(seg_static_sel)
    & $past(seg_dynamic_data)))) else $error("static segment select wrong");
  dyn_seg_a: assert property (clk_en |=> (pin_oe.seg & $past(pin_function_reg)) ==
    $past(pin_function_reg) && ((pin_out.seg ^ $past(dynamic_segment_outputs))
    & $past(pin_function_reg)) == 28'h0) else $error("dynamic segment pin wrong");
  rst_idle_a: assert property ($fell(reset) |-> pin_oe == '0 && !key_edge_request_flag)
    else $error("outputs not idle after reset");
endmodule // ppfm_port_mux_props

/* verif/tb_top.sv */
`timescale 1ns/10ps
module tb_top
  import ppfm_pkg::*;
;
  typedef struct packed {
    logic [IO_W-1:0] dir;
    logic [IO_W-1:0] lat;
    logic [IO_W-1:0] ext;
    logic [IO_W-1:0] oe;
    logic [IO_W-1:0] out;
    logic [IO_W-1:0] rd;
  } ppfm_row_t;

  logic                        mclk = 1'b0;
  logic                        reset;
  logic                        clk_en;
  ppfm_io_t                    dir, pull, latch, ext_lv, ext_dr;
  ppfm_io_t                    pin_in, pin_out, pin_oe, pull_en, rd;
  logic [7:0]                  m0, m1, m2, p1_in, p1_rd, adc;
  logic [5:0]                  m3;
  logic [SEGP_W-1:0]           pf, dyn;
  logic [SEGS_W-1:0]           sel, sdat, ddat, segs;
  ppfm_edge_t [IRQ_N-1:0]      edg;
  logic [IRQ_N-1:0]            irq;
  logic                        kclr, kflag;
  ppfm_periph_in_t             per_in;
  ppfm_periph_out_t            po;
  logic [8:0]                  g;
  int                          mismatches = 0;
  int                          comparisons = 0;
  ppfm_row_t                   rows [4] = '{
    '{'0, '1, '0, 58'h3ffffcf0fffffff, 58'h3ffffcf0fffffff, '1},
    '{'0, '0, '0, '1, '0, '0},
    '{'1, '1, 58'h2aaaaaaaaaaaaaa, '0, '0, 58'h2aaaaaaaaaaaaaa},
    '{58'h155555555555555, '0, '1, 58'h2aaaaaaaaaaaaaa, '0, 58'h155555555555555}};

  always #10 mclk = ~mclk;

  ppfm_port_mux ppfm_port_mux_i (
    .mclk(mclk), .reset(reset), .clk_en(clk_en),
    .port0_direction_reg(dir.p0), .port0_pullup_reg(pull.p0), .port0_mode(m0),
    .port1_mode(m1), .port2_direction_reg(dir.p2), .port2_pullup_reg(pull.p2),
    .port2_mode(m2), .port3_direction_reg(dir.p3), .port3_pullup_reg(pull.p3[5:2]),
    .port3_mode(m3), .port4_direction_reg(dir.p4), .port4_pullup_reg(pull.p4),
    .port7_direction_reg(dir.p7), .seg_port_direction_reg(dir.seg), .pin_function_reg(pf),
    .port_latch(latch), .pin_in(pin_in), .port1_pin_in(p1_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .pullup_en(pull_en), .port_read(rd), .port1_read(p1_rd),
    .adc_analog_inputs(adc), .ext_irq_edge(edg), .ext_irq_inputs(irq),
    .key_flag_clear(kclr), .key_edge_request_flag(kflag), .periph_out(po),
    .periph_in(per_in), .seg_static_sel(sel), .seg_static_data(sdat),
    .seg_dynamic_data(ddat), .dynamic_segment_outputs(dyn), .static_capable_segments(segs));

  ppfm_board_model ppfm_board_model_i (
    .mclk(mclk), .pin_out(pin_out), .pin_oe(pin_oe), .pullup_en(pull_en),
    .ext_level(ext_lv), .ext_drive(ext_dr), .pin_in(pin_in));

  // ---------------------------------------------------------------------------
  // Checking helpers
  // ---------------------------------------------------------------------------
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] s);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic grab;
    g = '0;
    repeat (10) begin
      @(posedge mclk);
      #1;
      g = g | {irq, per_in.timer16_capture_reg_a_trig, per_in.timer16_capture_reg_b_trig};
    end
  endtask

  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Stimulus
  // ---------------------------------------------------------------------------
  initial begin
    {reset, clk_en, kclr} = 3'b110;
    {dir, ext_dr} = {2*IO_W{1'b1}};
    {pull, latch, ext_lv} = '0;
    {m0, m1, m2, m3, p1_in, pf, dyn, sel, sdat, ddat} = '0;
    edg = {IRQ_N{EDGE_NONE}};
    po = '0;
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    wait_n(1);
    chk("pin_oe after reset", '0, pin_oe);
    chk("key flag after reset", 1'b0, kflag);
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      {dir, latch, ext_lv, ext_dr} <= {rows[i].dir, rows[i].lat, rows[i].ext, rows[i].dir};
      wait_n(6);
      chk("pin_oe", rows[i].oe, pin_oe);
      chk("pin_out", rows[i].out, pin_out & rows[i].oe);
      chk("port_read", rows[i].rd, rd);
    end
    @(posedge mclk);
    {dir, ext_dr, pull} <= {{IO_W{1'b1}}, {IO_W{1'b0}}, {IO_W{1'b1}}};
    wait_n(6);
    chk("pullup_en", 58'h3ffffcf00000000, pull_en);
    chk("pulled read", 58'h3ffffcf00000000, rd & 58'h3ffffcf00000000);
    {pull, ext_dr, ext_lv, m0} <= {{IO_W{1'b0}}, {IO_W{1'b1}}, {IO_W{1'b0}}, 8'h7f};
    for (int k = 0; k < IRQ_N; k++) begin
      edg[k] <= (k == 3) ? EDGE_NONE : ppfm_edge_t'((k % 3) + 1);
    end
    wait_n(6);
    ext_lv.p0 <= 8'hff;
    grab();
    chk("irq on rise", {7'h65, 2'b00}, g);
    chk("adc trigger", 1'b1, per_in.adc_ext_trigger);
    ext_lv.p0 <= 8'h00;
    grab();
    chk("irq on fall", {7'h36, 2'b00}, g);
    {m0, kclr} <= {8'h00, 1'b1};
    ext_lv.p4 <= 4'hf;
    @(posedge mclk);
    kclr <= 1'b0;
    wait_n(6);
    chk("key flag idle", 1'b0, kflag);
    ext_lv.p4 <= 4'hb;
    wait_n(6);
    chk("key flag set", 1'b1, kflag);
    ext_lv.p4 <= 4'hf;
    wait_n(6);
    chk("key flag kept", 1'b1, kflag);
    kclr <= 1'b1;
    @(posedge mclk);
    kclr <= 1'b0;
    wait_n(2);
    chk("key flag cleared", 1'b0, kflag);
    m3 <= 6'h30;
    wait_n(6);
    ext_lv.p3 <= 6'h20;
    grab();
    chk("capture on first input", 9'h003, g);
    ext_lv.p3 <= 6'h30;
    grab();
    chk("capture on second input", 9'h002, g);
    {m1, p1_in, sel, sdat, ddat, pf, dyn} <= {8'hf0, 8'ha5, 12'h0f0, 12'hfff, 12'h00f,
                                              28'h000000f, 28'h0000005};
    wait_n(6);
    chk("port1_read", 8'h05, p1_rd);
    chk("adc inputs", 8'ha0, adc);
    chk("static segments", 12'h0ff, segs);
    chk("segment enable", 28'h000000f, pin_oe.seg);
    chk("segment data", 28'h0000005, pin_out.seg & 28'h000000f);
    @(posedge mclk);
    {m0, m2, dir.p0} <= {8'he0, 8'hff, 8'h9f};
    {ext_lv.p0, ext_lv.p2} <= {8'h80, 8'h49};
    po <= '1;
    wait_n(8);
    chk("port 0 timer and clock drive", 8'h60, pin_oe.p0 & pin_out.p0);
    chk("timer b count in", 1'b1, per_in.timer_b_count_in);
    chk("port 2 serial enable", 8'hb6, pin_oe.p2);
    chk("port 2 serial drive", 8'hb6, pin_out.p2 & 8'hb6);
    chk("port 2 serial inputs", 5'h1f, per_in[12:8]);
    @(posedge mclk);
    {clk_en, ext_lv.p2} <= {1'b0, 8'h00};
    wait_n(8);
    chk("inputs held while frozen", 5'h1f, per_in[12:8]);
    tally_and_finish();
  end

  initial begin
    repeat (2000) @(posedge mclk);
    mismatches++;
    tally_and_finish();
  end
endmodule // tb_top

bind ppfm_port_mux ppfm_port_mux_props ppfm_port_mux_props_i (
  .mclk, .reset, .clk_en, .port0_direction_reg, .port0_mode, .port1_mode,
  .port7_direction_reg, .pin_function_reg, .port_latch, .pin_out, .pin_oe, .port_read,
  .port1_read, .adc_analog_inputs, .ext_irq_inputs, .key_flag_clear, .key_edge_request_flag,
  .periph_in, .seg_static_sel, .seg_static_data, .seg_dynamic_data,
  .dynamic_segment_outputs, .static_capable_segments);
